// ===== verilog/fsc_pkg.sv
`default_nettype none
package fsc_pkg;
    // register layout
    localparam int          ARG_W           = 32;
    localparam int          CMD_W           = 16;
    localparam int          TRIGGER_BIT     = 31;
    localparam int          ACTIVE_BIT      = 28;
    localparam int          RESULT_W        = 28;
    localparam logic        SEL_ARG         = 1'b0;
    localparam logic        SEL_REQ         = 1'b1;

    // guard bytes
    localparam logic [7:0]  FIRST_GUARD     = 8'hB6;
    localparam logic [7:0]  SECOND_GUARD    = 8'hD3;

    // status words
    localparam logic [3:0]  OK_NIBBLE       = 4'hA;
    localparam logic [23:0] FAIL_PREFIX     = 24'hF00000;
    localparam logic [7:0]  ERR_GUARD       = 8'h01;
    localparam logic [7:0]  ERR_NO_RESUME   = 8'h02;
    localparam logic [7:0]  ERR_BUSY        = 8'h03;

    // call opcodes, one byte each and all distinct
    localparam logic [7:0]  OP_SILICON_ID   = 8'h00;
    localparam logic [7:0]  OP_LOAD_BYTES   = 8'h04;
    localparam logic [7:0]  OP_WRITE_ROW    = 8'h05;
    localparam logic [7:0]  OP_PROGRAM_ROW  = 8'h06;
    localparam logic [7:0]  OP_NB_WRITE     = 8'h07;
    localparam logic [7:0]  OP_NB_PROGRAM   = 8'h08;
    localparam logic [7:0]  OP_RESUME       = 8'h09;
    localparam logic [7:0]  OP_ERASE_ALL    = 8'h0A;
    localparam logic [7:0]  OP_CHECKSUM     = 8'h0B;
    localparam logic [7:0]  OP_WRITE_PROT   = 8'h0D;

    // pulse kinds handed to the flash controller interface
    localparam logic [1:0]  KIND_PRESET     = 2'h0;
    localparam logic [1:0]  KIND_ERASE      = 2'h1;
    localparam logic [1:0]  KIND_PROGRAM    = 2'h2;
    localparam logic [1:0]  KIND_CALL       = 2'h3;
    localparam logic [1:0]  STEP_FIRST      = 2'h0;
    localparam logic [1:0]  STEP_LAST       = 2'h2;
    localparam logic [1:0]  STEP_ONE        = 2'h1;

    typedef enum logic [2:0] {
        FSC_IDLE, FSC_FETCH, FSC_CHECK, FSC_WAIT, FSC_FINISH
    } fsc_state_t;
endpackage
`default_nettype wire

// ===== verilog/fsc_request_port.sv
// What the document requires
// RL1 - each call has a distinct 8-bit opcode
// RL2 - requester supplies guard bytes B6 and D3+opcode
// RL3 - wrong guard bytes: skip call, report error
// RL4 - every call leaves a 32-bit status word
// RL5 - parameters in argument register or SRAM words
// RL6 - opcode in bits 7:0, zero in 15:8
// RL7 - trigger bit 31 raises non-maskable interrupt
// RL8 - only the call sets the active flag
// RL9 - completion clears trigger bit and active flag
// RL10 - debug requester aborts after one second
// RL11 - success leaves A nibble, failure F00000YY
// RL12 - results returned in argument and request
// RL13 - only the CPU starts non-blocking calls
// RL14 - three non-blocking calls, others block
// RL15 - one interrupt per finished sub-step
// RL16 - CPU resumes from the interrupt handler
// RL17 - non-blocking code must run from SRAM
// RL18 - preset, erase, then program the row
// RL19 - data goes through the page latch first
// RL20 - all flash writes pass one interface
// RL21 - no reset during a 20 ms write
// RL22 - trigger writes ignored while call active
`timescale 1ns/100ps
`default_nettype none
module fsc_request_port (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // register write port
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_sel,
    input  wire logic [31:0] i_reg_wdata,
    // register contents
    output logic      [31:0] o_syscall_argument,
    output logic      [31:0] o_syscall_request,
    output logic             o_nmi,
    // sram parameter fetch
    output logic             o_fetch_req,
    input  wire logic        i_fetch_valid,
    input  wire logic [31:0] i_fetch_data,
    // flash controller interface
    output logic             o_flash_start,
    output logic      [1:0]  o_flash_kind,
    input  wire logic        i_flash_done,
    input  wire logic        i_flash_fail,
    input  wire logic [7:0]  i_flash_code,
    input  wire logic [27:0] i_flash_result,
    input  wire logic [15:0] i_flash_ret,
    // non-blocking status
    output logic             o_step_irq,
    output logic             o_nb_busy
);
    ////////////////////////////////////////////////////////////////////////
    // decoding helpers
    function automatic logic keys_ok(input logic [31:0] w,
                                     input logic [7:0] op);
        logic [7:0] k2;
        k2 = fsc_pkg::SECOND_GUARD + op;
        keys_ok = (w[7:0] == fsc_pkg::FIRST_GUARD) && (w[15:8] == k2);
    endfunction

    function automatic logic is_row(input logic [7:0] op);
        is_row = (op == fsc_pkg::OP_WRITE_ROW) ||
                 (op == fsc_pkg::OP_PROGRAM_ROW) ||
                 (op == fsc_pkg::OP_NB_WRITE) ||
                 (op == fsc_pkg::OP_NB_PROGRAM);
    endfunction

    function automatic logic is_nb(input logic [7:0] op);
        is_nb = (op == fsc_pkg::OP_NB_WRITE) ||
                (op == fsc_pkg::OP_NB_PROGRAM);
    endfunction

    function automatic logic is_write(input logic [7:0] op);
        is_write = (op == fsc_pkg::OP_WRITE_ROW) ||
                   (op == fsc_pkg::OP_NB_WRITE);
    endfunction

    function automatic logic uses_sram(input logic [7:0] op);
        uses_sram = is_row(op) || (op == fsc_pkg::OP_LOAD_BYTES);
    endfunction

    function automatic logic [1:0] step_kind(input logic [1:0] idx);
        case (idx)
            fsc_pkg::STEP_FIRST: step_kind = fsc_pkg::KIND_PRESET;
            fsc_pkg::STEP_ONE:   step_kind = fsc_pkg::KIND_ERASE;
            default:             step_kind = fsc_pkg::KIND_PROGRAM;
        endcase
    endfunction

    function automatic logic [31:0] fail_word(input logic [7:0] code);
        fail_word = {fsc_pkg::FAIL_PREFIX, code};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state
    fsc_pkg::fsc_state_t state, next_state;
    logic [31:0] arg, next_arg, param, next_param;
    logic [15:0] cmd, next_cmd;
    logic        trig, next_trig, active, next_active;
    logic [1:0]  step, next_step, next_kind;
    logic        nb_pend, next_nb_pend, nb_ready, next_nb_ready;
    logic        nb_fail, next_nb_fail;
    logic [7:0]  nb_code, next_nb_code;
    logic        next_nmi, next_start, next_irq, next_fetch;

    // RL1 opcode field
    wire  [7:0]  opcode  = cmd[7:0];
    wire         req_wr  = i_reg_wr && (i_reg_sel == fsc_pkg::SEL_REQ);
    wire         arg_wr  = i_reg_wr && (i_reg_sel == fsc_pkg::SEL_ARG);
    wire  [7:0]  new_op  = i_reg_wdata[7:0];
    wire  [1:0]  first_step = is_write(opcode) ? fsc_pkg::STEP_FIRST
                                               : fsc_pkg::STEP_LAST;
    wire  [1:0]  step_inc = step + fsc_pkg::STEP_ONE;
    wire  [31:0] ok_word = {fsc_pkg::OK_NIBBLE, {fsc_pkg::RESULT_W{1'b0}}};

    // the active flag sits in the request word; software cannot write it
    assign o_syscall_argument = arg;
    assign o_syscall_request  = {trig, 2'b00, active, 12'h000, cmd};
    assign o_nb_busy          = nb_pend;

    ////////////////////////////////////////////////////////////////////////
    // next-state decode
    always_comb begin
        next_state   = state;
        next_arg     = arg;
        next_param   = param;
        next_cmd     = cmd;
        next_trig    = trig;
        next_active  = active;
        next_step    = step;
        next_kind    = o_flash_kind;
        next_nb_pend = nb_pend;
        next_nb_ready = nb_ready;
        next_nb_fail = nb_fail;
        next_nb_code = nb_code;
        next_nmi     = 1'b0;
        next_start   = 1'b0;
        next_irq     = 1'b0;
        next_fetch   = 1'b0;
        // RL15 sub-step interrupt
        if (nb_pend && !nb_ready && i_flash_done) begin
            next_irq      = 1'b1;
            next_nb_ready = 1'b1;
            next_nb_fail  = i_flash_fail;
            next_nb_code  = i_flash_code;
        end
        case (state)
            fsc_pkg::FSC_IDLE: begin
                if (arg_wr) begin
                    next_arg = i_reg_wdata;
                end
                // RL7 trigger starts call
                if (req_wr) begin
                    next_cmd = i_reg_wdata[fsc_pkg::CMD_W-1:0];
                    if (i_reg_wdata[fsc_pkg::TRIGGER_BIT]) begin
                        next_trig   = 1'b1;
                        // RL8 set by the call
                        next_active = 1'b1;
                        next_nmi    = 1'b1;
                        next_param  = arg;
                        next_fetch  = uses_sram(new_op);
                        next_state  = uses_sram(new_op) ? fsc_pkg::FSC_FETCH
                                                        : fsc_pkg::FSC_CHECK;
                    end
                end
            end
            // RL5 sram parameter block
            fsc_pkg::FSC_FETCH: begin
                next_fetch = !i_fetch_valid;
                if (i_fetch_valid) begin
                    next_param = i_fetch_data;
                    next_state = fsc_pkg::FSC_CHECK;
                end
            end
            fsc_pkg::FSC_CHECK: begin
                next_state = fsc_pkg::FSC_FINISH;
                // RL3 guard byte check
                if (!keys_ok(param, opcode)) begin
                    next_arg = fail_word(fsc_pkg::ERR_GUARD);
                end else if (opcode == fsc_pkg::OP_RESUME) begin
                    // RL14 resume next step
                    if (!nb_pend || !nb_ready) begin
                        next_arg = fail_word(fsc_pkg::ERR_NO_RESUME);
                    end else if (nb_fail || step == fsc_pkg::STEP_LAST) begin
                        next_arg      = nb_fail ? fail_word(nb_code) : ok_word;
                        next_nb_pend  = 1'b0;
                        next_nb_ready = 1'b0;
                    end else begin
                        next_step     = step_inc;
                        next_kind     = step_kind(step_inc);
                        next_start    = 1'b1;
                        next_nb_ready = 1'b0;
                        next_arg      = ok_word;
                    end
                end else if (nb_pend) begin
                    next_arg = fail_word(fsc_pkg::ERR_BUSY);
                end else begin
                    // RL20 single flash path
                    next_start = 1'b1;
                    next_step  = first_step;
                    // RL19 latch loads go first
                    next_kind  = is_row(opcode) ? step_kind(first_step)
                                                : fsc_pkg::KIND_CALL;
                    if (is_nb(opcode)) begin
                        next_nb_pend  = 1'b1;
                        next_nb_ready = 1'b0;
                        next_arg      = ok_word;
                    end else begin
                        next_state = fsc_pkg::FSC_WAIT;
                    end
                end
            end
            fsc_pkg::FSC_WAIT: begin
                if (i_flash_done) begin
                    if (i_flash_fail) begin
                        // RL11 failure word
                        next_arg   = fail_word(i_flash_code);
                        next_state = fsc_pkg::FSC_FINISH;
                    end else if (is_row(opcode) &&
                                 step != fsc_pkg::STEP_LAST) begin
                        // RL18 preset erase program
                        next_step  = step_inc;
                        next_kind  = step_kind(step_inc);
                        next_start = 1'b1;
                    end else begin
                        // RL12 results returned
                        next_arg   = {fsc_pkg::OK_NIBBLE, i_flash_result};
                        next_cmd   = i_flash_ret;
                        next_state = fsc_pkg::FSC_FINISH;
                    end
                end
            end
            fsc_pkg::FSC_FINISH: begin
                // RL9 completion clears flags
                next_trig   = 1'b0;
                next_active = 1'b0;
                next_state  = fsc_pkg::FSC_IDLE;
            end
            default: begin
                next_state = fsc_pkg::FSC_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // control flops; requests outside idle are dropped
    // RL22 ignore busy writes
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state         <= fsc_pkg::FSC_IDLE;
            trig          <= 1'b0;
            active        <= 1'b0;
            step          <= fsc_pkg::STEP_FIRST;
            nb_pend       <= 1'b0;
            nb_ready      <= 1'b0;
            nb_fail       <= 1'b0;
            nb_code       <= 8'h00;
            o_nmi         <= 1'b0;
            o_fetch_req   <= 1'b0;
            o_flash_start <= 1'b0;
            o_flash_kind  <= fsc_pkg::KIND_PRESET;
            o_step_irq    <= 1'b0;
        end else begin
            state         <= next_state;
            trig          <= next_trig;
            active        <= next_active;
            step          <= next_step;
            nb_pend       <= next_nb_pend;
            nb_ready      <= next_nb_ready;
            nb_fail       <= next_nb_fail;
            nb_code       <= next_nb_code;
            o_nmi         <= next_nmi;
            o_fetch_req   <= next_fetch;
            o_flash_start <= next_start;
            o_flash_kind  <= next_kind;
            o_step_irq    <= next_irq;
        end
    end

    // RL4 status word storage
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            arg   <= 32'h00000000;
            param <= 32'h00000000;
            cmd   <= 16'h0000;
        end else begin
            arg   <= next_arg;
            param <= next_param;
            cmd   <= next_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks; last started kind kept only for the order check
    logic [1:0] last_kind;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            last_kind <= fsc_pkg::KIND_CALL;
        end else if (o_flash_start) begin
            last_kind <= o_flash_kind;
        end
    end

    chk_nmi_sets_flags: assert property ( // RL7
        @(posedge i_sys_clk) disable iff (i_rst)
        o_nmi |-> (trig && active))
        else $error("interrupt without trigger and active flag");
    chk_active_by_call: assert property ( // RL8
        @(posedge i_sys_clk) disable iff (i_rst)
        $rose(active) |-> o_nmi)
        else $error("active flag set without a call start");
    chk_finish_clears: assert property ( // RL9
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == fsc_pkg::FSC_FINISH)
        |=> (!trig && !active && state == fsc_pkg::FSC_IDLE))
        else $error("completion left a flag standing");
    chk_guard_error: assert property ( // RL3
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == fsc_pkg::FSC_CHECK && !keys_ok(param, opcode))
        |=> (arg == {fsc_pkg::FAIL_PREFIX, fsc_pkg::ERR_GUARD})
            && !o_flash_start)
        else $error("bad guard bytes not reported");
    chk_busy_ignored: assert property ( // RL22
        @(posedge i_sys_clk) disable iff (i_rst)
        (active && req_wr) |=> !o_nmi)
        else $error("trigger accepted while active");
    chk_success_code: assert property ( // RL11
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == fsc_pkg::FSC_WAIT && i_flash_done && !i_flash_fail
         && (!is_row(opcode) || step == fsc_pkg::STEP_LAST))
        |=> (arg[31:28] == fsc_pkg::OK_NIBBLE) ##1 !active)
        else $error("success word missing");
    chk_pep_order: assert property ( // RL18
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_flash_start && o_flash_kind == fsc_pkg::KIND_ERASE)
        |-> (last_kind == fsc_pkg::KIND_PRESET))
        else $error("erase not preceded by preset");
    chk_step_irq: assert property ( // RL15
        @(posedge i_sys_clk) disable iff (i_rst)
        (nb_pend && !nb_ready && i_flash_done) |=> o_step_irq && nb_ready)
        else $error("sub-step interrupt missing");
    chk_blocking_hold: assert property ( // RL14
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == fsc_pkg::FSC_WAIT) |-> (active && trig && !nb_pend))
        else $error("blocking call released early");
endmodule // fsc_request_port
`default_nettype wire

// ===== tb/fsc_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fsc_flash_model (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // sram parameter side
    input  wire logic        i_fetch_req,
    input  wire logic [31:0] i_word,
    output logic             o_fetch_valid,
    output logic      [31:0] o_fetch_data,
    // flash controller side
    input  wire logic        i_flash_start,
    input  wire logic [7:0]  i_delay,
    input  wire logic        i_fail,
    output logic             o_flash_done,
    output logic             o_flash_fail,
    output logic      [7:0]  o_flash_code,
    output logic      [27:0] o_flash_result,
    output logic      [15:0] o_flash_ret
);
    int fcnt;
    int wcnt;
    // fixed return values; only meaningful with a done pulse
    assign o_flash_result = 28'h1234567;
    assign o_flash_ret    = 16'h4321;
    // sram word served three cycles after the fetch request
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            fcnt          <= 0;
            o_fetch_valid <= 1'b0;
            o_fetch_data  <= 32'h0;
        end else if (!o_fetch_valid && i_fetch_req && fcnt == 2) begin
            o_fetch_valid <= 1'b1;
            o_fetch_data  <= i_word;
            fcnt          <= 0;
        end else begin
            // data inverted every cycle when not valid so a stale word is not held
            o_fetch_valid <= 1'b0;
            o_fetch_data  <= ~o_fetch_data;
            fcnt          <= (i_fetch_req && !o_fetch_valid) ? fcnt + 1 : 0;
        end
    end
    // every pulse answered after i_delay cycles, no reset meanwhile
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wcnt         <= 0;
            o_flash_done <= 1'b0;
            o_flash_fail <= 1'b0;
            o_flash_code <= 8'h00;
        end else begin
            wcnt         <= i_flash_start ? int'(i_delay)
                                          : (wcnt != 0 ? wcnt - 1 : 0);
            o_flash_done <= (wcnt == 1) && !i_flash_start;
            // fail and code toggle outside done, they are not held
            o_flash_fail <= (wcnt == 1) ? i_fail : ~o_flash_fail;
            o_flash_code <= (wcnt == 1) ? 8'h5C : ~o_flash_code;
        end
    end
endmodule // fsc_flash_model
`default_nettype wire

// ===== tb/tb_flash_system_call_request_port.sv
`timescale 1ns/100ps
`default_nettype none
module tb_flash_system_call_request_port;
    logic        clk, rst, wr, sel, fv, fs, fd, ff, irq, nmi, busy, fail;
    logic [31:0] wd, arg, req, fdat, word;
    logic [1:0]  kind;
    logic [7:0]  code, delay;
    logic [27:0] res;
    logic [15:0] ret;
    logic        freq;
    logic [1:0]  kq[$];
    logic [3:0]  top_at_nmi;
    int          n_fail, cmp_count, n_nmi, n_irq;
    fsc_request_port DUT (.i_sys_clk(clk), .i_rst(rst), .i_reg_wr(wr),
        .i_reg_sel(sel), .i_reg_wdata(wd), .o_syscall_argument(arg),
        .o_syscall_request(req), .o_nmi(nmi), .o_fetch_req(freq),
        .i_fetch_valid(fv), .i_fetch_data(fdat), .o_flash_start(fs),
        .o_flash_kind(kind), .i_flash_done(fd), .i_flash_fail(ff),
        .i_flash_code(code), .i_flash_result(res), .i_flash_ret(ret),
        .o_step_irq(irq), .o_nb_busy(busy));
    fsc_flash_model u_model (.i_sys_clk(clk), .i_rst(rst),
        .i_fetch_req(freq), .i_word(word), .o_fetch_valid(fv),
        .o_fetch_data(fdat), .i_flash_start(fs), .i_delay(delay),
        .i_fail(fail), .o_flash_done(fd), .o_flash_fail(ff),
        .o_flash_code(code), .o_flash_result(res), .o_flash_ret(ret));
    // clock at 250 MHz
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // observers: pulses counted where they stand for one cycle
    always @(negedge clk) begin
        if (nmi === 1'b1) begin
            n_nmi++;
            top_at_nmi = req[31:28];
        end
        if (irq === 1'b1) n_irq++;
        if (fs === 1'b1) kq.push_back(kind);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one write pulse, then one idle cycle before the next may start
    task automatic wreg(input logic s, input logic [31:0] d);
        @(negedge clk);
        wr  = 1'b1;
        sel = s;
        wd  = d;
        @(negedge clk);
        wr  = 1'b0;
    endtask
    function automatic logic [31:0] keys(input logic [7:0] op);
        keys = {16'h0000, fsc_pkg::SECOND_GUARD + op, fsc_pkg::FIRST_GUARD};
    endfunction
    // bounded poll of trigger and active bits
    task automatic wait_idle;
        int k;
        for (k = 0; k < 300 && (req[31] !== 1'b0 || req[28] !== 1'b0); k++)
            @(negedge clk);
        chk({req[31], req[28]}, 32'h0);
    endtask
    // opcode in [7:0], zero in [15:8], trigger bit set
    task automatic call(input logic [31:0] a, input logic [7:0] op);
        wreg(fsc_pkg::SEL_ARG, a);
        wreg(fsc_pkg::SEL_REQ, {16'h8000, 8'h00, op});
        wait_idle();
    endtask
    task automatic wait_irq(input int n);
        int k;
        for (k = 0; k < 300 && n_irq < n; k++) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk(arg, 32'h0);
        chk(req, 32'h0);
        chk({nmi, fs, irq, busy, freq, kind}, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_reg_calls;
        logic [7:0] ops[4];
        int         i, n0;
        ops = '{fsc_pkg::OP_SILICON_ID, fsc_pkg::OP_CHECKSUM,
                fsc_pkg::OP_ERASE_ALL, fsc_pkg::OP_WRITE_PROT};
        for (i = 0; i < 4; i++) begin
            n0 = n_nmi;
            call(keys(ops[i]), ops[i]);
            chk(n_nmi - n0, 1);
            chk(top_at_nmi, 4'h9);
            chk(arg[31:28], fsc_pkg::OK_NIBBLE);
            if (i < 2) chk(arg, {4'hA, 28'h1234567});
            if (i < 2) chk(req[15:0], 16'h4321);
        end
        $display("test register calls done");
    endtask
    task automatic t_guard;
        int n0;
        n0 = kq.size();
        call(32'h0000D3B7, fsc_pkg::OP_SILICON_ID);
        chk(arg, {fsc_pkg::FAIL_PREFIX, fsc_pkg::ERR_GUARD});
        call(32'h0000D2B6, fsc_pkg::OP_SILICON_ID);
        chk(arg, {fsc_pkg::FAIL_PREFIX, fsc_pkg::ERR_GUARD});
        chk(kq.size() - n0, 0);
        wreg(fsc_pkg::SEL_REQ, 32'h10000000);
        @(negedge clk);
        chk(req[28], 1'b0);
        $display("test guard done");
    endtask
    task automatic t_busy_writes;
        int n0;
        delay = 8'd30;
        n0    = n_nmi;
        wreg(fsc_pkg::SEL_ARG, keys(fsc_pkg::OP_SILICON_ID));
        wreg(fsc_pkg::SEL_REQ, 32'h80000000);
        wreg(fsc_pkg::SEL_ARG, 32'h00000000);
        wreg(fsc_pkg::SEL_REQ, 32'h80000000);
        wait_idle();
        chk(n_nmi - n0, 1);
        chk(arg, {4'hA, 28'h1234567});
        delay = 8'd5;
        $display("test busy writes done");
    endtask
    task automatic t_write_row;
        int i;
        word = keys(fsc_pkg::OP_WRITE_ROW);
        kq.delete();
        call(32'h00000100, fsc_pkg::OP_WRITE_ROW);
        chk(kq.size(), 3);
        for (i = 0; i < 3; i++) chk(kq[i], i);
        chk(arg[31:28], fsc_pkg::OK_NIBBLE);
        fail = 1'b1;
        call(32'h00000100, fsc_pkg::OP_WRITE_ROW);
        chk(arg, {fsc_pkg::FAIL_PREFIX, 8'h5C});
        fail = 1'b0;
        // program row and latch load take one flash step each
        word = keys(fsc_pkg::OP_PROGRAM_ROW);
        kq.delete();
        call(32'h00000100, fsc_pkg::OP_PROGRAM_ROW);
        chk(kq.size(), 1);
        chk(kq[0], fsc_pkg::KIND_PROGRAM);
        word = keys(fsc_pkg::OP_LOAD_BYTES);
        call(32'h00000104, fsc_pkg::OP_LOAD_BYTES);
        chk(kq[1], fsc_pkg::KIND_CALL);
        chk(arg, {4'hA, 28'h1234567});
        // bad guard bytes in the fetched sram word
        word = 32'h0000D6B6;
        call(32'h00000104, fsc_pkg::OP_LOAD_BYTES);
        chk(arg, {fsc_pkg::FAIL_PREFIX, fsc_pkg::ERR_GUARD});
        chk(kq.size(), 2);
        $display("test write row done");
    endtask
    task automatic t_nb_program;
        int n0;
        delay = 8'd60;
        word  = keys(fsc_pkg::OP_NB_PROGRAM);
        n0    = n_irq;
        kq.delete();
        call(32'h00000200, fsc_pkg::OP_NB_PROGRAM);
        chk(arg, 32'hA0000000);
        chk(busy, 1'b1);
        call(keys(fsc_pkg::OP_RESUME), fsc_pkg::OP_RESUME);
        chk(arg, {fsc_pkg::FAIL_PREFIX, fsc_pkg::ERR_NO_RESUME});
        call(keys(fsc_pkg::OP_SILICON_ID), fsc_pkg::OP_SILICON_ID);
        chk(arg, {fsc_pkg::FAIL_PREFIX, fsc_pkg::ERR_BUSY});
        wait_irq(n0 + 1);
        call(keys(fsc_pkg::OP_RESUME), fsc_pkg::OP_RESUME);
        chk(arg, 32'hA0000000);
        chk(busy, 1'b0);
        chk(n_irq - n0, 1);
        chk(kq.size(), 1);
        chk(kq[0], fsc_pkg::KIND_PROGRAM);
        delay = 8'd5;
        $display("test nb program done");
    endtask
    task automatic t_nb_write;
        int i, n0;
        word = keys(fsc_pkg::OP_NB_WRITE);
        n0   = n_irq;
        kq.delete();
        call(32'h00000300, fsc_pkg::OP_NB_WRITE);
        for (i = 0; i < 3; i++) begin
            wait_irq(n0 + i + 1);
            chk(busy, 1'b1);
            call(keys(fsc_pkg::OP_RESUME), fsc_pkg::OP_RESUME);
            chk(arg, 32'hA0000000);
        end
        chk(busy, 1'b0);
        chk(n_irq - n0, 3);
        for (i = 0; i < 3; i++) chk(kq[i], i);
        $display("test nb write done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence: reset held for 8 cycles, inputs move on falling edges
    initial begin
        {wr, sel, fail} = 3'b000;
        {wd, word}      = 64'h0;
        delay           = 8'd5;
        rst             = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_reg_calls();
        t_guard();
        t_busy_writes();
        t_write_row();
        t_nb_program();
        t_nb_write();
        test_done();
    end
    // watchdog: the tests take a few hundred cycles
    initial begin
        #(20000 * 4);
        n_fail++;
        test_done();
    end
endmodule // tb_flash_system_call_request_port
`default_nettype wire
